// ==== pkg/cbal_pkg.sv ====
package cbal_pkg;
  localparam int NCELL = 12;
  localparam int NLOC  = 13;
  localparam logic [3:0] PTR_MAX   = 4'hc;
  localparam logic [3:0] PTR_FIRST = 4'h1;
  // register select codes on the register port
  localparam logic [1:0] A_SETUP = 2'h0;
  localparam logic [1:0] A_SEL   = 2'h1;
  localparam logic [1:0] A_WDBT  = 2'h2;
  // field positions
  localparam int RUN_B   = 9;
  localparam int PTR_HI  = 8;
  localparam int PTR_LO  = 5;
  localparam int WAIT_HI = 4;
  localparam int WAIT_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam int BTM_HI  = 13;
  localparam int BTM_LO  = 7;
  // balance mode field values
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_MAN  = 2'h1;
  localparam logic [1:0] MODE_TIM  = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  // reset values
  localparam logic [9:0]  SETUP_RST = 10'h000;
  localparam logic [11:0] SEL_RST   = 12'h000;
  localparam logic [13:0] WDBT_RST  = 14'h0000;
  localparam logic [27:0] BV_RST    = 28'h0000000;
  // timing: one tick per second, duration step of 20 s
  localparam int CLK_NS   = 10;
  localparam int TICK_S   = 1;
  localparam int TICK_CYC = TICK_S * 1_000_000_000 / CLK_NS;
  localparam logic [11:0] STEP_S = 12'h014;
  typedef enum logic [1:0] {CMD_EN, CMD_INH, CMD_SLEEP, CMD_WAKE} cmd_e;
  // wait interval code to seconds: 0,1,2,4,...,64
  function automatic logic [11:0] wait_sec(input logic [2:0] c);
    wait_sec = (c == 3'h0) ? 12'h000 : (12'h001 << (c - 3'h1));
  endfunction : wait_sec
endpackage : cbal_pkg

// ==== logic/tick_gen.sv ====
`timescale 1ns/1ps
module tick_gen #(
  parameter int CYC = 100
) (
  // clock and reset
  input  logic clk_sys,
  input  logic rst_n,
  // one-cycle enable
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb begin
    cnt_d = (cnt_q >= 32'(CYC - 1)) ? 32'h0 : cnt_q + 32'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q >= 32'(CYC - 1));
endmodule : tick_gen

// ==== logic/cell_balance_controller.sv ====
`timescale 1ns/1ps
module cell_balance_controller #(
  parameter int TICK_CYC = cbal_pkg::TICK_CYC
) (
  // clock and reset
  input  logic                 clk_sys,
  input  logic                 arst_n,
  // register port
  input  logic                 reg_wr,
  input  logic                 reg_rd,
  input  logic [1:0]           reg_addr,
  input  logic [13:0]          reg_wdata,
  output logic [13:0]          reg_rdata,
  // balance value load
  input  logic                 bv_wr,
  input  logic [3:0]           bv_cell,
  input  logic [27:0]          bv_wdata,
  // commands
  input  logic                 cmd_valid,
  input  cbal_pkg::cmd_e       cmd_code,
  input  logic                 cmd_bcast,
  input  logic                 cmd_own,
  // watchdog
  input  logic                 wdog_on,
  input  logic                 wdog_expire,
  // measurement
  output logic                 scan_req,
  input  logic                 scan_done,
  input  logic                 meas_valid,
  input  logic [3:0]           meas_cell,
  input  logic [12:0]          meas_value,
  // status and switches
  input  logic [1:0]           flag_clr,
  output logic [11:0]          cell_drain_select,
  output logic                 balancing_done_flag,
  output logic                 watchdog_expired_flag,
  output logic                 asleep
);
  import cbal_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_MEAS, ST_WAIT} st_e;

  logic [1:0]  rst_sq;
  logic        rst_n;
  logic        tick;
  st_e         st_q, st_d;
  logic [9:0]  setup_q, setup_d;
  logic [11:0] sel_q [NLOC];
  logic [11:0] sel_d [NLOC];
  logic [13:0] wdbt_q, wdbt_d;
  logic [27:0] bv_q [NCELL];
  logic [27:0] bv_d [NCELL];
  logic [11:0] tmr_q, tmr_d;
  logic [11:0] out_q, out_d;
  logic [11:0] drained_q, drained_d;
  logic [13:0] rdata_q, rdata_d;
  logic        sleep_q, sleep_d;
  logic        pend_q, pend_d;
  logic        wdarm_q, wdarm_d;
  logic        done_q, done_d;
  logic        wdf_q, wdf_d;
  logic        scan_q, scan_d;
  logic [11:0] nz;
  logic        run_q;
  logic [3:0]  ptr_q;
  logic [1:0]  mode_q;
  logic [11:0] dur;
  logic [3:0]  nx_raw;
  logic        wrap_w;
  logic        cmd_ok;
  logic        cmd_all;
  logic        start_w;
  logic        stop_w;
  logic        quiet_w;
  logic        adv_w;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sq <= 2'h0;
    end else begin
      rst_sq <= {rst_sq[0], 1'b1};
    end
  end
  assign rst_n = rst_sq[1];

  tick_gen #(.CYC(TICK_CYC)) u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  assign run_q  = setup_q[RUN_B];
  assign ptr_q  = setup_q[PTR_HI:PTR_LO];
  assign mode_q = setup_q[MODE_HI:MODE_LO];
  assign dur    = 12'(wdbt_q[BTM_HI:BTM_LO]) * STEP_S;
  assign nx_raw = ptr_q + 4'h1;
  // a zero pattern or the last location sends the sequence back to 1
  assign wrap_w = (ptr_q >= PTR_MAX) ? 1'b1 : (sel_q[nx_raw] == 12'h000);
  assign cmd_ok  = cmd_valid && (cmd_bcast || cmd_own);
  assign cmd_all = cmd_valid && cmd_bcast;
  assign start_w = (cmd_ok && cmd_code == CMD_EN) ||
                   (reg_wr && reg_addr == A_SETUP && reg_wdata[RUN_B] && !run_q);
  assign stop_w  = (cmd_ok && cmd_code == CMD_INH) ||
                   (reg_wr && reg_addr == A_SETUP && !reg_wdata[RUN_B]);
  assign quiet_w = !reg_wr && !cmd_valid && !wdog_expire && !bv_wr;
  assign adv_w   = st_q == ST_WAIT && tmr_q == 12'h000 && !sleep_q && quiet_w;

  // finished cells drop out of every pattern in auto mode; manual and timed modes drive location zero unmasked
  for (genvar i = 0; i < NCELL; i++) begin : g_nz
    assign nz[i] = |bv_q[i];
  end

  always_comb begin
    setup_d   = setup_q;
    sel_d     = sel_q;
    wdbt_d    = wdbt_q;
    bv_d      = bv_q;
    st_d      = st_q;
    tmr_d     = tmr_q;
    drained_d = drained_q;
    sleep_d   = sleep_q;
    pend_d    = pend_q;
    wdarm_d   = wdarm_q;
    done_d    = done_q & ~flag_clr[0];
    wdf_d     = wdf_q & ~flag_clr[1];
    scan_d    = 1'b0;
    rdata_d   = rdata_q;
    out_d     = 12'h000;
    if (reg_rd) begin
      if (reg_addr == A_SETUP) begin
        rdata_d = 14'(setup_q);
      end else if (reg_addr == A_SEL) begin
        rdata_d = (ptr_q <= PTR_MAX) ? 14'(sel_q[ptr_q]) : 14'h0000;
      end else if (reg_addr == A_WDBT) begin
        rdata_d = wdbt_q;
      end else begin
        rdata_d = 14'h0000;
      end
    end
    if (reg_wr) begin
      if (reg_addr == A_SETUP) begin
        setup_d = {setup_q[RUN_B], reg_wdata[PTR_HI:0]};
      end else if (reg_addr == A_SEL && ptr_q <= PTR_MAX) begin
        sel_d[ptr_q] = reg_wdata[11:0];
      end else if (reg_addr == A_WDBT) begin
        wdbt_d = reg_wdata;
      end
    end
    if (bv_wr && 32'(bv_cell) < NCELL) begin
      bv_d[bv_cell] = bv_wdata;
    end
    case (st_q)
      ST_ON: begin
        if (mode_q == MODE_TIM) begin
          // keeps counting while asleep
          if (tick && tmr_q != 12'h000) begin
            tmr_d = tmr_q - 12'h001;
            if (tmr_q == 12'h001) begin
              setup_d[RUN_B] = 1'b0;
              done_d = 1'b1;
              st_d = ST_IDLE;
            end
          end
        end else if (mode_q == MODE_AUTO && !sleep_q && tick) begin
          if (tmr_q == 12'h000) begin
            st_d = ST_MEAS;
            scan_d = 1'b1;
            drained_d = out_q;
          end else begin
            tmr_d = tmr_q - 12'h001;
          end
        end
      end
      ST_MEAS: begin
        if (meas_valid && 32'(meas_cell) < NCELL && drained_q[meas_cell]) begin
          // saturate so a cell never wraps past zero
          bv_d[meas_cell] = (bv_q[meas_cell] > 28'(meas_value)) ?
                            bv_q[meas_cell] - 28'(meas_value) : BV_RST;
        end
        if (scan_done) begin
          if (nz == 12'h000) begin
            setup_d[RUN_B] = 1'b0;
            done_d = 1'b1;
            st_d = ST_IDLE;
            if (pend_q) begin
              sleep_d = 1'b1;
              pend_d = 1'b0;
            end
          end else begin
            st_d = ST_WAIT;
            tmr_d = wait_sec(setup_q[WAIT_HI:WAIT_LO]);
          end
        end
      end
      ST_WAIT: begin
        if (!sleep_q) begin
          if (tmr_q == 12'h000) begin
            setup_d[PTR_HI:PTR_LO] = wrap_w ? PTR_FIRST : nx_raw;
            st_d = ST_ON;
            tmr_d = dur;
          end else if (tick) begin
            tmr_d = tmr_q - 12'h001;
          end
        end
      end
      default: begin
      end
    endcase
    if (start_w) begin
      setup_d[RUN_B] = 1'b1;
      st_d = ST_ON;
      tmr_d = dur;
      if (setup_d[MODE_HI:MODE_LO] == MODE_AUTO) begin
        setup_d[PTR_HI:PTR_LO] = PTR_FIRST;
      end
    end
    if (stop_w) begin
      setup_d[RUN_B] = 1'b0;
      st_d = ST_IDLE;
      tmr_d = 12'h000;
    end
    if (cmd_all && cmd_code == CMD_SLEEP) begin
      // auto without watchdog finishes its work before sleeping
      if (mode_q == MODE_AUTO && st_q != ST_IDLE && !wdog_on) begin
        pend_d = 1'b1;
      end else begin
        sleep_d = 1'b1;
        wdarm_d = wdog_on;
      end
    end
    if (cmd_all && cmd_code == CMD_WAKE) begin
      sleep_d = 1'b0;
      pend_d = 1'b0;
    end
    if (wdog_expire) begin
      if (wdarm_q && sleep_q) begin
        wdf_d = 1'b1;
        wdarm_d = 1'b0;
      end else if (!sleep_q && run_q) begin
        sleep_d = 1'b1;
        setup_d[RUN_B] = 1'b0;
        st_d = ST_IDLE;
        tmr_d = 12'h000;
        wdf_d = 1'b1;
      end
    end
    if (setup_d[RUN_B] && !sleep_d) begin
      if (setup_d[MODE_HI:MODE_LO] == MODE_MAN || setup_d[MODE_HI:MODE_LO] == MODE_TIM) begin
        out_d = sel_d[0];
      end else if (setup_d[MODE_HI:MODE_LO] == MODE_AUTO && st_d == ST_ON &&
                   setup_d[PTR_HI:PTR_LO] <= PTR_MAX) begin
        out_d = sel_d[setup_d[PTR_HI:PTR_LO]] & nz;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      setup_q   <= SETUP_RST;
      sel_q     <= '{default: SEL_RST};
      wdbt_q    <= WDBT_RST;
      bv_q      <= '{default: BV_RST};
      tmr_q     <= 12'h000;
      out_q     <= 12'h000;
      drained_q <= 12'h000;
      rdata_q   <= 14'h0000;
      sleep_q   <= 1'b0;
      pend_q    <= 1'b0;
      wdarm_q   <= 1'b0;
      done_q    <= 1'b0;
      wdf_q     <= 1'b0;
      scan_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      setup_q   <= setup_d;
      sel_q     <= sel_d;
      wdbt_q    <= wdbt_d;
      bv_q      <= bv_d;
      tmr_q     <= tmr_d;
      out_q     <= out_d;
      drained_q <= drained_d;
      rdata_q   <= rdata_d;
      sleep_q   <= sleep_d;
      pend_q    <= pend_d;
      wdarm_q   <= wdarm_d;
      done_q    <= done_d;
      wdf_q     <= wdf_d;
      scan_q    <= scan_d;
    end
  end

  assign reg_rdata             = rdata_q;
  assign cell_drain_select     = out_q;
  assign balancing_done_flag   = done_q;
  assign watchdog_expired_flag = wdf_q;
  assign asleep                = sleep_q;
  assign scan_req              = scan_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_on_end;
    st_q == ST_ON && mode_q == MODE_AUTO && tmr_q == 12'h000 && tick && !sleep_q && quiet_w;
  endsequence
  sequence s_scan_pulse;
    scan_req ##1 !scan_req;
  endsequence

  a_sleep_outputs_off:
    assert property (asleep |-> cell_drain_select == 12'h000)
    else $error("outputs active while asleep");
  a_inhibit_stops:
    assert property (cmd_ok && cmd_code == CMD_INH && !reg_wr |=>
                     !run_q && cell_drain_select == 12'h000)
    else $error("inhibit did not stop balancing");
  a_manual_select:
    assert property (run_q && !asleep && mode_q == MODE_MAN |-> cell_drain_select == sel_q[0])
    else $error("manual outputs differ from location zero");
  a_timed_expiry:
    assert property (st_q == ST_ON && mode_q == MODE_TIM && tmr_q == 12'h001 && tick && quiet_w
                     |=> balancing_done_flag && !run_q)
    else $error("timed expiry did not end balancing");
  a_scan_after_on:
    assert property (s_on_end |=> s_scan_pulse)
    else $error("no single scan request after on-time");
  a_auto_wrap:
    assert property (adv_w && wrap_w |=> ptr_q == PTR_FIRST && st_q == ST_ON)
    else $error("pointer did not wrap to first location");
  a_auto_step:
    assert property (adv_w && !wrap_w |=> ptr_q == $past(ptr_q) + 4'h1)
    else $error("pointer did not advance by one");
  a_meas_sat:
    assert property (st_q == ST_MEAS && meas_valid && 32'(meas_cell) < NCELL && !bv_wr &&
                     drained_q[meas_cell] && 28'(meas_value) >= bv_q[meas_cell]
                     |=> bv_q[$past(meas_cell)] == BV_RST)
    else $error("balance value not cleared by large measurement");
  a_wdog_sleep:
    assert property (wdog_expire && run_q && !asleep && !cmd_valid
                     |=> asleep && watchdog_expired_flag && cell_drain_select == 12'h000)
    else $error("watchdog expiry did not stop and sleep");
endmodule : cell_balance_controller

// ==== verification/meas_model.sv ====
`timescale 1ns/1ps
module meas_model (
  // clock
  input  wire logic        clk_sys,
  // scan handshake
  input  wire logic        scan_req,
  output logic             scan_done,
  // per-cell results
  output logic             meas_valid,
  output logic [3:0]       meas_cell,
  output logic [12:0]      meas_value
);
  // reports all twelve cells; the block must drop the undrained ones itself
  initial begin
    scan_done  = 1'b0;
    meas_valid = 1'b0;
    meas_cell  = 4'hf;
    meas_value = 13'h1fff;
    forever begin
      @(posedge clk_sys);
      if (scan_req === 1'b1) begin
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 12; i++) begin
          meas_valid = 1'b1;
          meas_cell  = i[3:0];
          meas_value = 13'h0006;
          @(negedge clk_sys);
        end
        // released lines toggle so a stale sample cannot look valid
        meas_valid = 1'b0;
        meas_cell  = 4'hf;
        meas_value = ~meas_value;
        scan_done  = 1'b1;
        @(negedge clk_sys);
        scan_done  = 1'b0;
      end
    end
  end
endmodule : meas_model

// ==== verification/tb_cell_balance_controller.sv ====
`timescale 1ns/1ps
module tb_cell_balance_controller;
  import cbal_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [13:0] reg_wdata = 14'h0000;
  logic [13:0] reg_rdata;
  logic        bv_wr = 1'b0;
  logic [3:0]  bv_cell = 4'h0;
  logic [27:0] bv_wdata = 28'h0000000;
  logic        cmd_valid = 1'b0;
  cmd_e        cmd_code = CMD_EN;
  logic        cmd_bcast = 1'b0;
  logic        cmd_own = 1'b0;
  logic        wdog_on = 1'b0;
  logic        wdog_expire = 1'b0;
  logic        scan_req, scan_done, meas_valid;
  logic [3:0]  meas_cell;
  logic [12:0] meas_value;
  logic [1:0]  flag_clr = 2'h0;
  logic [11:0] cell_drain_select;
  logic        balancing_done_flag, watchdog_expired_flag, asleep;
  int          num_errors = 0;
  int          total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  cell_balance_controller #(.TICK_CYC(4)) cell_balance_controller_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bv_wr(bv_wr),
    .bv_cell(bv_cell), .bv_wdata(bv_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bcast(cmd_bcast), .cmd_own(cmd_own), .wdog_on(wdog_on), .wdog_expire(wdog_expire),
    .scan_req(scan_req), .scan_done(scan_done), .meas_valid(meas_valid),
    .meas_cell(meas_cell), .meas_value(meas_value), .flag_clr(flag_clr),
    .cell_drain_select(cell_drain_select), .balancing_done_flag(balancing_done_flag),
    .watchdog_expired_flag(watchdog_expired_flag), .asleep(asleep));

  meas_model meas_model_i (.clk_sys(clk_sys), .scan_req(scan_req), .scan_done(scan_done),
    .meas_valid(meas_valid), .meas_cell(meas_cell), .meas_value(meas_value));

  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_out(input logic [11:0] drn, input logic slp, input logic dn, input logic wd);
    chk({cell_drain_select, asleep, balancing_done_flag}, {drn, slp, dn});
    chk({13'h0000, watchdog_expired_flag}, {13'h0000, wd});
  endtask : chk_out

  task automatic wr(input logic [1:0] a, input logic [13:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [13:0] exp, input logic [13:0] msk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata & msk, exp);
  endtask : rd

  task automatic cmd(input cmd_e c, input logic b, input logic o);
    cmd_code  = c;
    cmd_bcast = b;
    cmd_own   = o;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
  endtask : cmd

  task automatic pulse_in(input logic [2:0] p);
    {wdog_expire, flag_clr} = p;
    @(negedge clk_sys);
    {wdog_expire, flag_clr} = 3'h0;
    @(negedge clk_sys);
  endtask : pulse_in

  // bounded waits: an auto on-time is only one tick long, so poll every cycle
  task automatic wait_drain(input logic [11:0] exp);
    for (int n = 0; n < 400 && cell_drain_select !== exp; n++) @(negedge clk_sys);
    chk({2'h0, cell_drain_select}, {2'h0, exp});
  endtask : wait_drain

  task automatic wait_done;
    for (int n = 0; n < 400 && balancing_done_flag !== 1'b1; n++) @(negedge clk_sys);
  endtask : wait_done

  task automatic t_regs;
    rd(A_SETUP, 14'h0000, 14'h3fff);
    rd(A_WDBT, 14'h0000, 14'h3fff);
    wr(2'h3, 14'h3fff);
    rd(2'h3, 14'h0000, 14'h3fff);
    rd(A_SETUP, 14'h0000, 14'h3fff);
  endtask : t_regs

  task automatic t_manual;
    wr(A_SETUP, 14'h0001);
    wr(A_SEL, 14'h3815);
    rd(A_SEL, 14'h0815, 14'h3fff);
    chk_out(12'h000, 1'b0, 1'b0, 1'b0);
    wr(A_SETUP, 14'h0201);
    rd(A_SETUP, 14'h0201, 14'h3fff);
    chk_out(12'h815, 1'b0, 1'b0, 1'b0);
    cmd(CMD_INH, 1'b1, 1'b0);
    chk_out(12'h000, 1'b0, 1'b0, 1'b0);
    cmd(CMD_EN, 1'b1, 1'b0);
    chk_out(12'h815, 1'b0, 1'b0, 1'b0);
    cmd(CMD_SLEEP, 1'b0, 1'b1);
    chk_out(12'h815, 1'b0, 1'b0, 1'b0);
    cmd(CMD_SLEEP, 1'b1, 1'b0);
    chk_out(12'h000, 1'b1, 1'b0, 1'b0);
    cmd(CMD_WAKE, 1'b1, 1'b0);
    chk_out(12'h815, 1'b0, 1'b0, 1'b0);
  endtask : t_manual

  task automatic t_wdog;
    wdog_on = 1'b1;
    cmd(CMD_SLEEP, 1'b1, 1'b0);
    chk_out(12'h000, 1'b1, 1'b0, 1'b0);
    pulse_in(3'h4);
    chk_out(12'h000, 1'b1, 1'b0, 1'b1);
    pulse_in(3'h2);
    cmd(CMD_WAKE, 1'b1, 1'b0);
    wr(A_SETUP, 14'h0201);
    chk_out(12'h815, 1'b0, 1'b0, 1'b0);
    pulse_in(3'h4);
    chk_out(12'h000, 1'b1, 1'b0, 1'b1);
    cmd(CMD_WAKE, 1'b1, 1'b0);
    pulse_in(3'h2);
    wdog_on = 1'b0;
    wr(A_SETUP, 14'h0000);
    chk_out(12'h000, 1'b0, 1'b0, 1'b0);
  endtask : t_wdog

  // one 20 s step is 80 cycles with a four-cycle tick
  task automatic t_timed;
    wr(A_WDBT, 14'h0080);
    rd(A_WDBT, 14'h0080, 14'h3fff);
    wr(A_SEL, 14'h0240);
    wr(A_SETUP, 14'h0202);
    chk_out(12'h240, 1'b0, 1'b0, 1'b0);
    repeat (50) @(negedge clk_sys);
    wr(A_SETUP, 14'h0002);
    chk_out(12'h000, 1'b0, 1'b0, 1'b0);
    wr(A_SETUP, 14'h0202);
    repeat (60) @(negedge clk_sys);
    chk_out(12'h240, 1'b0, 1'b0, 1'b0);
    wait_done();
    chk_out(12'h000, 1'b0, 1'b1, 1'b0);
    rd(A_SETUP, 14'h0002, 14'h3fff);
    pulse_in(3'h1);
  endtask : t_timed

  // timer keeps running asleep: resume while time is left, stay idle once it ran out
  task automatic t_sleep_timed;
    cmd(CMD_EN, 1'b0, 1'b1);
    chk_out(12'h240, 1'b0, 1'b0, 1'b0);
    cmd(CMD_SLEEP, 1'b1, 1'b0);
    chk_out(12'h000, 1'b1, 1'b0, 1'b0);
    repeat (20) @(negedge clk_sys);
    cmd(CMD_WAKE, 1'b1, 1'b0);
    chk_out(12'h240, 1'b0, 1'b0, 1'b0);
    cmd(CMD_SLEEP, 1'b1, 1'b0);
    wait_done();
    chk_out(12'h000, 1'b1, 1'b1, 1'b0);
    cmd(CMD_WAKE, 1'b1, 1'b0);
    chk_out(12'h000, 1'b0, 1'b1, 1'b0);
    rd(A_SETUP, 14'h0000, 14'h0200);
    pulse_in(3'h1);
  endtask : t_sleep_timed

  task automatic t_auto;
    wr(A_WDBT, 14'h0000);
    wr(A_SETUP, 14'h0023);
    wr(A_SEL, 14'h0001);
    wr(A_SETUP, 14'h0043);
    wr(A_SEL, 14'h0002);
    wr(A_SETUP, 14'h0063);
    wr(A_SEL, 14'h0000);
    for (int c = 0; c < 2; c++) begin
      bv_cell  = c[3:0];
      bv_wdata = 28'h000000a;
      bv_wr    = 1'b1;
      @(negedge clk_sys);
      bv_wr = 1'b0;
      @(negedge clk_sys);
    end
    wr(A_SETUP, 14'h0203);
    wait_drain(12'h001);
    wait_drain(12'h002);
    wait_drain(12'h001);
    // sleep without watchdog is held off until the auto run ends
    cmd(CMD_SLEEP, 1'b1, 1'b0);
    wait_drain(12'h002);
    wait_done();
    chk_out(12'h000, 1'b1, 1'b1, 1'b0);
    rd(A_SETUP, 14'h0000, 14'h0200);
    cmd(CMD_WAKE, 1'b1, 1'b0);
  endtask : t_auto

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_regs();
    t_manual();
    t_wdog();
    t_timed();
    t_sleep_timed();
    t_auto();
    complete_run();
  end
endmodule : tb_cell_balance_controller
